// *** hdl/csoc_pkg.sv ***
// Package with register map, field layout and timing constants for the clock status block.
package csoc_pkg;
   // Register byte offsets.
   localparam logic [11:0] STATUS_OFS = 12'h000;
   localparam logic [11:0] OSCCTL_OFS = 12'h004;
   localparam logic [11:0] TRIM_OFS = 12'h008;
   localparam logic [11:0] DETCTL_OFS = 12'h00C;
   // Reset values.
   localparam logic [31:0] OSCCTL_RESET = 32'h00FF_F001;
   localparam logic [31:0] TRIM_RESET = 32'h0000_0000;
   // Writable bit masks; positions above each top field are dropped, oscillator control bits 6 and 10:8 are kept.
   localparam logic [31:0] OSCCTL_MASK = 32'h00FF_FFFF;
   localparam logic [31:0] TRIM_MASK = 32'h0000_001F;
   localparam logic [31:0] DETCTL_MASK = 32'h0000_0003;
   // Oscillator control field positions.
   localparam int TMO_LSB = 12;
   localparam int TMO_MSB = 23;
   localparam int DET_EN_BIT = 11;
   localparam int PULLDN_BIT = 7;
   localparam int EXTSEL_BIT = 5;
   localparam int XEN_BIT = 4;
   localparam int KICK_BIT = 3;
   localparam int BYP_BIT = 2;
   localparam int SWCTL_BIT = 1;
   localparam int HFO_BIT = 0;
   // Extra slow-clock cycles added to the activation timeout.
   localparam logic [12:0] TMO_EXTRA = 13'h0008;
   // AHB transfer type of interest.
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // Live indications from the analog clock generator.
   typedef struct packed {
      logic contactlessSecondLock;
      logic contactlessSecondBypass;
      logic contactlessFirstLock;
      logic contactlessDetectDone;
      logic contactlessClockOk;
      logic crystalClockSeen;
      logic crystalReady;
      logic crystalActive;
      logic usbLock;
      logic usbLoopFreeRunning;
      logic postDividerChangeAck;
      logic preDividerChangeAck;
      logic feedbackDividerChangeAck;
      logic usbDetectDone;
      logic usbClockOk;
      logic [7:0] usbEdgeCount;
   } csoc_ana_t;

   // Crystal and fast oscillator controls sent to the analog part.
   typedef struct packed {
      logic crystalEnable;
      logic crystalKick;
      logic crystalBypass;
      logic crystalExternal;
      logic crystalPulldownOn;
      logic crystalDetectOn;
      logic fastOscillatorOn;
      logic [4:0] fastOscillatorTrimValue;
   } csoc_ctl_t;
endpackage : csoc_pkg

// *** hdl/csoc_top.sv ***
// Clock status word, crystal and fast oscillator control behind AHB-Lite.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Bit 26 mirrors the second contactless PLL lock.
// - Bit 25 sets when crystal activation times out without activity.
// - Bit 24 reports crystal clock seen, only while detection is enabled.
// - Bit 23 reports crystal clock ready.
// - Bit 22 is second contactless lock OR its lock bypass.
// - Bits 21 and 20 give contactless detect done and clock ok.
// - Bits 19 and 18 give second and first contactless lock.
// - Bit 17 crystal activated, bit 16 crystal enabled.
// - Bits 15:8 hold edge count captured on successful USB detection.
// - Bits 7 and 6 give USB detect done and clock ok.
// - Bit 5 shows USB loop free running.
// - Bits 4..2 show post, pre and feedback divider change acks.
// - Bit 0 USB lock, bit 1 USB lock OR lock bypass.
// - Writes to unused control bits 31:24 are ignored; unused bits 6 and 10:8 store.
// - Bits 23:12 set activation timeout in slow cycles plus 8.
// - Bit 11 enables crystal detection only while USB detect enable low.
// - Bit 7 turns on the strong crystal pull-down.
// - Bit 5 selects external clock under software control.
// - Bits 4, 3, 2 enable, kick, bypass crystal under software control.
// - Bit 1 hands crystal control to software.
// - Bit 0 enables fast oscillator, reset value one.
module csoc_top (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire csoc_pkg::csoc_ana_t anaStatus,
   input wire logic slowOscillatorTick,
   input wire logic hwCrystalEnable,
   input wire logic hwCrystalKick,
   input wire logic hwCrystalBypass,
   input wire logic hwCrystalExternal,
   input wire logic contactlessSecondBypass,
   output csoc_pkg::csoc_ctl_t oscControl,
   output logic activationTimeoutError
);
   // Both analog indications and the slow tick are asynchronous to core_clk.
   localparam int ANA_W = $bits(csoc_pkg::csoc_ana_t);
   logic [ANA_W-1:0] anaMeta_reg;
   logic [ANA_W-1:0] anaSync_reg;
   logic [4:0] hwMeta_reg;
   logic [4:0] hwSync_reg;
   logic slowMeta_reg;
   logic slowSync_reg;
   logic slowPrev_reg;
   csoc_pkg::csoc_ana_t ana;

   // Two-stage synchronisers; only the second stage feeds logic.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         anaMeta_reg <= '0;
         anaSync_reg <= '0;
         hwMeta_reg <= '0;
         hwSync_reg <= '0;
         slowMeta_reg <= 1'b0;
         slowSync_reg <= 1'b0;
         slowPrev_reg <= 1'b0;
      end else begin
         anaMeta_reg <= anaStatus;
         anaSync_reg <= anaMeta_reg;
         hwMeta_reg <= {contactlessSecondBypass, hwCrystalExternal,
                        hwCrystalBypass, hwCrystalKick, hwCrystalEnable};
         hwSync_reg <= hwMeta_reg;
         slowMeta_reg <= slowOscillatorTick;
         slowSync_reg <= slowMeta_reg;
         slowPrev_reg <= slowSync_reg;
      end
   end
   assign ana = csoc_pkg::csoc_ana_t'(anaSync_reg);

   // AHB address phase capture.
   logic wrPend_reg;
   logic rdPend_reg;
   logic [11:0] addrPend_reg;
   wire logic takeXfer;
   assign takeXfer = hsel && hready && (htrans == csoc_pkg::HTRANS_NONSEQ);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPend_reg <= 1'b0;
         rdPend_reg <= 1'b0;
         addrPend_reg <= 12'h000;
      end else if (hready) begin
         wrPend_reg <= takeXfer && hwrite;
         rdPend_reg <= takeXfer && !hwrite;
         addrPend_reg <= haddr[11:0];
      end
   end

   // Write decode; the status offset has no write strobe at all.
   wire logic wrOsc;
   wire logic wrTrim;
   wire logic wrDet;
   assign wrOsc = wrPend_reg && (addrPend_reg == csoc_pkg::OSCCTL_OFS);
   assign wrTrim = wrPend_reg && (addrPend_reg == csoc_pkg::TRIM_OFS);
   assign wrDet = wrPend_reg && (addrPend_reg == csoc_pkg::DETCTL_OFS);

   // Software registers; masks keep unused bits at zero, except oscCtl bits 6 and 10:8, which store.
   logic [31:0] oscCtl_reg;
   logic [31:0] trim_reg;
   logic [1:0] detCtl_reg;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         oscCtl_reg <= csoc_pkg::OSCCTL_RESET;
         trim_reg <= csoc_pkg::TRIM_RESET;
         detCtl_reg <= 2'b00;
      end else begin
         if (wrOsc) begin
            oscCtl_reg <= hwdata & csoc_pkg::OSCCTL_MASK;
         end
         if (wrTrim) begin
            trim_reg <= hwdata & csoc_pkg::TRIM_MASK;
         end
         if (wrDet) begin
            detCtl_reg <= hwdata[1:0];
         end
      end
   end

   // Field views of the oscillator control and detect control words.
   wire logic swCtl;
   wire logic usbDetectEnable;
   wire logic crystalDetectOn;
   wire logic [11:0] timeoutField;
   assign swCtl = oscCtl_reg[csoc_pkg::SWCTL_BIT];
   assign usbDetectEnable = detCtl_reg[0];
   assign timeoutField = oscCtl_reg[csoc_pkg::TMO_MSB:csoc_pkg::TMO_LSB];
   // Crystal detection yields to the USB input clock detector.
   assign crystalDetectOn = oscCtl_reg[csoc_pkg::DET_EN_BIT]
                            && !usbDetectEnable;

   // Software override mux; hardware sequencer drives otherwise.
   csoc_pkg::csoc_ctl_t ctlNext;
   always_comb begin
      ctlNext.crystalEnable = swCtl ? oscCtl_reg[csoc_pkg::XEN_BIT]
                                    : hwSync_reg[0];
      ctlNext.crystalKick = swCtl ? oscCtl_reg[csoc_pkg::KICK_BIT]
                                  : hwSync_reg[1];
      ctlNext.crystalBypass = swCtl ? oscCtl_reg[csoc_pkg::BYP_BIT]
                                    : hwSync_reg[2];
      ctlNext.crystalExternal = swCtl ? oscCtl_reg[csoc_pkg::EXTSEL_BIT]
                                      : hwSync_reg[3];
      ctlNext.crystalPulldownOn = oscCtl_reg[csoc_pkg::PULLDN_BIT];
      ctlNext.crystalDetectOn = crystalDetectOn;
      ctlNext.fastOscillatorOn = oscCtl_reg[csoc_pkg::HFO_BIT];
      ctlNext.fastOscillatorTrimValue = trim_reg[4:0];
   end

   // Activation timer runs on slow-clock ticks while the crystal is enabled.
   wire logic slowTick;
   assign slowTick = slowSync_reg && !slowPrev_reg;
   logic [12:0] actCount_reg;
   logic tmoErr_reg;
   logic crystalEnPrev_reg;
   wire logic [12:0] tmoLimit;
   assign tmoLimit = {1'b0, timeoutField} + csoc_pkg::TMO_EXTRA;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         actCount_reg <= 13'h0000;
         tmoErr_reg <= 1'b0;
         crystalEnPrev_reg <= 1'b0;
      end else begin
         crystalEnPrev_reg <= ctlNext.crystalEnable;
         // A fresh enable restarts the timer and clears a stale error.
         if (ctlNext.crystalEnable && !crystalEnPrev_reg) begin
            actCount_reg <= 13'h0000;
            tmoErr_reg <= 1'b0;
         end else if (ctlNext.crystalEnable && !ana.crystalActive
                      && !tmoErr_reg && slowTick) begin
            if (actCount_reg + 13'h0001 >= tmoLimit) begin
               tmoErr_reg <= 1'b1;
            end
            actCount_reg <= actCount_reg + 13'h0001;
         end
      end
   end

   // Captured edge count, taken only on a successful USB detection.
   logic [7:0] edgeCount_reg;
   logic doneSeen_reg;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         edgeCount_reg <= 8'h00;
         doneSeen_reg <= 1'b0;
      end else begin
         doneSeen_reg <= ana.usbDetectDone;
         if (ana.usbDetectDone && !doneSeen_reg && ana.usbClockOk) begin
            edgeCount_reg <= ana.usbEdgeCount;
         end
      end
   end

   // Status word assembly; it has no storage that software can write.
   wire logic [31:0] statusWord;
   assign statusWord = {5'b00000,
                        ana.contactlessSecondLock,
                        tmoErr_reg,
                        ana.crystalClockSeen && crystalDetectOn,
                        ana.crystalReady,
                        ana.contactlessSecondLock
                        || hwSync_reg[4],
                        ana.contactlessDetectDone,
                        ana.contactlessClockOk,
                        ana.contactlessSecondLock,
                        ana.contactlessFirstLock,
                        ana.crystalActive,
                        oscControl.crystalEnable,
                        edgeCount_reg,
                        ana.usbDetectDone,
                        ana.usbClockOk,
                        ana.usbLoopFreeRunning,
                        ana.postDividerChangeAck,
                        ana.preDividerChangeAck,
                        ana.feedbackDividerChangeAck,
                        ana.usbLock || detCtl_reg[1],
                        ana.usbLock};

   // Read mux; unmapped offsets read zero.
   wire logic [31:0] readMux;
   assign readMux = (addrPend_reg == csoc_pkg::STATUS_OFS) ? statusWord :
                    (addrPend_reg == csoc_pkg::OSCCTL_OFS) ? oscCtl_reg :
                    (addrPend_reg == csoc_pkg::TRIM_OFS) ? trim_reg :
                    (addrPend_reg == csoc_pkg::DETCTL_OFS) ?
                    {30'h0, detCtl_reg} : 32'h0000_0000;

   // Registered outputs; a read drops hreadyout at its address edge.
   // The wait state is what lets hrdata come from a flip-flop; the price
   // is one extra cycle on every read.
   wire logic takeRead;
   assign takeRead = takeXfer && !hwrite;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         oscControl <= '0;
         activationTimeoutError <= 1'b0;
      end else begin
         hresp <= 1'b0;
         oscControl <= ctlNext;
         activationTimeoutError <= tmoErr_reg;
         hreadyout <= !takeRead;
         // Load once, in the wait cycle, so the data stand until next read.
         if (rdPend_reg && !hreadyout) begin
            hrdata <= readMux;
         end
      end
   end
endmodule : csoc_top
`default_nettype wire

// *** verif/csoc_assertions.sv ***
// Bus timing and control output assertions for the clock status block.
`timescale 1ns/1ps
`default_nettype none
module csoc_assertions (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire csoc_pkg::csoc_ctl_t oscControl,
   input wire logic activationTimeoutError
);
   logic acc;
   logic oscWr;
   logic trimWr;
   logic rdUnm;
   // A transfer is taken only when selected, ready and NONSEQ.
   assign acc = hsel && hready && htrans == csoc_pkg::HTRANS_NONSEQ;
   // Track which access is in its data phase; hwdata is valid there only.
   always_ff @(posedge core_clk) begin
      oscWr <= acc && hwrite && haddr[11:0] == csoc_pkg::OSCCTL_OFS;
      trimWr <= acc && hwrite && haddr[11:0] == csoc_pkg::TRIM_OFS;
      rdUnm <= acc && !hwrite && haddr == 32'h0000_0010;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   hresp_okay_a: assert property (!hresp)
      else $error("hresp left OKAY");
   read_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state is not exactly one cycle");
   write_nowait_a: assert property (acc && hwrite |=> hreadyout)
      else $error("write inserted a wait state");
   idle_ready_a: assert property (!acc && hreadyout |=> hreadyout)
      else $error("hreadyout dropped without a read");
   hfo_reset_a: assert property ($fell(reset) |=> oscControl.fastOscillatorOn)
      else $error("fast oscillator off after reset");
   pulldown_wr_a: assert property (oscWr |-> ##2
      oscControl.crystalPulldownOn == $past(hwdata[7], 2))
      else $error("pull-down does not follow control write");
   trim_wr_a: assert property (trimWr |-> ##2
      oscControl.fastOscillatorTrimValue == $past(hwdata[4:0], 2))
      else $error("trim output does not follow trim write");
   unmapped_zero_a: assert property (rdUnm |=> hrdata == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   cover property (acc && !hwrite);
   cover property (trimWr);
   cover property ($rose(activationTimeoutError));
endmodule : csoc_assertions
bind csoc_top csoc_assertions u_csoc_assertions (.core_clk, .reset, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .oscControl, .activationTimeoutError);
`default_nettype wire

// *** verif/test_clock_status_and_oscillator_control.sv ***
// Register-level testbench for the clock status block.
`timescale 1ns/1ps
`default_nettype none
module test_clock_status_and_oscillator_control;
   localparam logic [11:0] ST = csoc_pkg::STATUS_OFS;
   logic core_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic tick, hwEn, scBypass, timeoutErr;
   csoc_pkg::csoc_ana_t ana;
   csoc_pkg::csoc_ctl_t ctl;
   int failures, tests_run;
   int pos[13] = '{22, 20, 19, 18, 16, 15, 14, 13, 12, 11, 10, 9, 8};
   logic [31:0] e[13] = '{32'h0448_0000, 32'h0004_0000, 32'h0020_0000,
      32'h0010_0000, 32'h0080_0000, 32'h0002_0000, 32'h0000_0003,
      32'h0000_0020, 32'h0000_0010, 32'h0000_0008, 32'h0000_0004,
      32'h0000_0080, 32'h0000_0040};
   // The single slave's hreadyout is the bus's hready.
   assign hready = hreadyout;
   csoc_top u_csoc_top (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
      .anaStatus(ana), .slowOscillatorTick(tick), .hwCrystalEnable(hwEn),
      .hwCrystalKick(hwEn), .hwCrystalBypass(hwEn), .hwCrystalExternal(hwEn),
      .contactlessSecondBypass(scBypass), .oscControl(ctl),
      .activationTimeoutError(timeoutErr));
   // A 200 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits for hready at a rising edge; a stuck bus ends the run.
   task automatic waitRdy;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         failures++;
         print_verdict();
      end
   endtask : waitRdy
   // One single AHB transfer; read data lands in r.
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= csoc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {20'h0_0000, a};
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      r = hrdata;
   endtask : xfer
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   // Inputs pass two sync flops, so four cycles lets them settle.
   task automatic settle;
      repeat (4) @(posedge core_clk);
   endtask : settle
   // Main sequence.
   initial begin
      {reset, hsel, hwrite, tick, hwEn, scBypass} = 6'h20;
      haddr = '0;
      htrans = 2'h0;
      hwdata = '0;
      ana = '0;
      failures = 0;
      tests_run = 0;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd(csoc_pkg::OSCCTL_OFS, 32'h00FF_F001);
      rd(csoc_pkg::TRIM_OFS, 32'h0000_0000);
      wr(ST, 32'hFFFF_FFFF);
      rd(ST, 32'h0000_0000);
      wr(csoc_pkg::TRIM_OFS, 32'hFFFF_FFFF);
      rd(csoc_pkg::TRIM_OFS, 32'h0000_001F);
      wr(csoc_pkg::OSCCTL_OFS, 32'hFFFF_FFFE);
      rd(csoc_pkg::OSCCTL_OFS, 32'h00FF_FFFE);
      rd(12'h010, 32'h0000_0000);
      chk(32'(ctl), 32'h0000_0FDF);
      rd(ST, 32'h0001_0000);
      ana.crystalClockSeen <= 1'b1;
      settle();
      rd(ST, 32'h0101_0000);
      wr(csoc_pkg::DETCTL_OFS, 32'h0000_0001);
      settle();
      rd(ST, 32'h0001_0000);
      chk(32'(ctl.crystalDetectOn), 32'h0000_0000);
      wr(csoc_pkg::DETCTL_OFS, 32'h0000_0002);
      settle();
      rd(ST, 32'h0101_0002);
      wr(csoc_pkg::DETCTL_OFS, 32'h0000_0000);
      ana <= '0;
      wr(csoc_pkg::OSCCTL_OFS, 32'h00FF_F03D);
      settle();
      chk(32'(ctl[11:8]), 32'h0000_0000);
      hwEn <= 1'b1;
      settle();
      chk(32'(ctl[11:8]), 32'h0000_000F);
      hwEn <= 1'b0;
      // Each live source alone except contactless second bypass, crystal clock seen and the edge count, with the crystal idle.
      for (int i = 0; i < 13; i++) begin
         ana <= csoc_pkg::csoc_ana_t'(23'h1 << pos[i]);
         settle();
         rd(ST, e[i]);
         chk(r & 32'h0000_003F, e[i] & 32'h0000_003F);
      end
      ana <= '0;
      scBypass <= 1'b1;
      settle();
      rd(ST, 32'h0040_0000);
      scBypass <= 1'b0;
      // Timeout field 1 means the error appears on the ninth slow edge.
      wr(csoc_pkg::OSCCTL_OFS, 32'h0000_1013);
      for (int i = 1; i <= 9; i++) begin
         tick <= 1'b1;
         settle();
         tick <= 1'b0;
         settle();
         chk(32'(timeoutErr), 32'(i > 8));
      end
      rd(ST, 32'h0201_0000);
      ana.usbClockOk <= 1'b1;
      ana.usbEdgeCount <= 8'hA5;
      settle();
      ana.usbDetectDone <= 1'b1;
      settle();
      ana.usbEdgeCount <= 8'h5A;
      settle();
      rd(ST, 32'h0201_A5C0);
      print_verdict();
   end
endmodule : test_clock_status_and_oscillator_control
`default_nettype wire
